// File: bench/prdt_ring_model.sv
`timescale 1ns/10ps
// ==========
// shared ring memory of four slots
module prdt_ring_model (
	// clock and reset
	input wire logic          clk_sys,
	input wire logic          rstn,
	// descriptor memory slave
	input wire logic          mem_rd,
	input wire logic          mem_wr,
	input wire logic [63:0]   mem_addr,
	input wire logic [127:0]  mem_wdata,
	output logic              mem_ack,
	output logic [127:0]      mem_rdata
);
	logic [127:0] ring [0:3] = '{default: 128'h0};
	int unsigned  wait_r;
	always @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			mem_ack <= 1'b0;
			mem_rdata <= 128'h0;
			wait_r <= 0;
		end
		else
		begin
			mem_ack <= 1'b0;
			// read data is garbage outside an answer
			mem_rdata <= ~mem_rdata;
			if ((mem_rd || mem_wr) && !mem_ack)
			begin
				if (wait_r == 0)
				begin
					mem_ack <= 1'b1;
					if (mem_wr)
						ring[mem_addr[5:4]] <= mem_wdata;
					else
						mem_rdata <= ring[mem_addr[5:4]];
					wait_r <= $urandom_range(3, 0);
				end
				else
					wait_r <= wait_r - 1;
			end
		end
	end
endmodule : prdt_ring_model

// File: bench/prdt_tracker_assertions.sv
`timescale 1ns/10ps
// ==========
// port checker for the ring tracker
module prdt_assertions (
	// clock and reset
	input wire logic         clk_sys,
	input wire logic         rstn,
	// register bus
	input wire logic [2:0]   avs_address,
	input wire logic         avs_read,
	input wire logic         avs_write,
	input wire logic [31:0]  avs_readdata,
	input wire logic         avs_waitrequest,
	// descriptor memory
	input wire logic         mem_rd,
	input wire logic         mem_wr,
	input wire logic [63:0]  mem_addr,
	input wire logic [127:0] mem_wdata,
	input wire logic         mem_ack,
	// elements and completion
	input wire logic         el_valid,
	input wire logic         el_ready,
	input wire logic [31:0]  el_len,
	input wire logic         el_last,
	input wire logic         cpl_valid,
	input wire logic         cpl_ready,
	input wire logic         cpl_written,
	input wire logic [31:0]  cpl_len
);
	localparam int FU = prdt_pkg::DESC_FLAGS_LSB + prdt_pkg::FLAG_USED_BIT;
	localparam int FA = prdt_pkg::DESC_FLAGS_LSB + prdt_pkg::FLAG_AVAIL_BIT;
	localparam int FW = prdt_pkg::DESC_FLAGS_LSB + prdt_pkg::FLAG_WRITE_BIT;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);
	sequence el_take;
		el_valid && el_ready;
	endsequence
	sequence cpl_take;
		cpl_valid && cpl_ready;
	endsequence
	bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("register access not answered");
	bus_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	unmapped_zero_a: assert property (avs_read && avs_address == 3'h7 && !avs_waitrequest |-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	mem_hold_a: assert property ((mem_rd || mem_wr) && !mem_ack |=> (mem_rd || mem_wr) && $stable(mem_addr))
		else $error("memory request not held");
	mem_release_a: assert property ((mem_rd || mem_wr) && mem_ack |=> !mem_rd && !mem_wr)
		else $error("memory request not released");
	el_hold_a: assert property (el_valid && !el_ready |=> el_valid && $stable(el_len) && $stable(el_last))
		else $error("element not held");
	el_gap_a: assert property (el_take |=> !el_valid [*2])
		else $error("element without new fetch");
	used_marks_a: assert property (mem_wr |-> mem_wdata[FA] == mem_wdata[FU])
		else $error("used markers differ");
	used_write_a: assert property (cpl_take |=> mem_wr && mem_wdata[FW] == $past(cpl_written)
		&& (!$past(cpl_written) || mem_wdata[95:64] == $past(cpl_len)))
		else $error("used descriptor does not match completion");
	one_used_a: assert property (el_take ##0 !el_last |=> !cpl_ready)
		else $error("completion offered inside a list");
endmodule : prdt_assertions

bind prdt_tracker prdt_assertions u_chk (.clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
	.el_valid(el_valid), .el_ready(el_ready), .el_len(el_len), .el_last(el_last), .cpl_valid(cpl_valid),
	.cpl_ready(cpl_ready), .cpl_written(cpl_written), .cpl_len(cpl_len));

// File: bench/testbench.sv
`timescale 1ns/10ps
module testbench;
	logic clk_sys = 1'b0, rstn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
	logic el_ready = 1'b0, cpl_valid = 1'b0, cpl_written = 1'b0;
	logic [2:0] avs_address = 3'h0;
	logic [31:0] avs_writedata = 32'h0, cpl_len = 32'h0, avs_readdata, el_len;
	logic avs_waitrequest, mem_rd, mem_wr, mem_ack, el_valid, el_write, el_indirect, el_last, cpl_ready;
	logic [63:0] mem_addr, el_addr;
	logic [127:0] mem_wdata, mem_rdata;
	int miscompares = 0, tests_run = 0;
	logic [98:0] el_q[$];
	logic [127:0] used_q[$];
	logic [32:0] cpl_q[$];
	logic drv_wrap = 1'b1, dev_wrap = 1'b1;
	localparam logic [63:0] BASE = 64'h0000_0002_0000_4000;
	always #25 clk_sys = ~clk_sys;
	prdt_tracker DUT (.clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .el_valid(el_valid), .el_ready(el_ready),
		.el_addr(el_addr), .el_len(el_len), .el_write(el_write), .el_indirect(el_indirect), .el_last(el_last),
		.cpl_valid(cpl_valid), .cpl_ready(cpl_ready), .cpl_written(cpl_written), .cpl_len(cpl_len));
	prdt_ring_model MEM (.clk_sys(clk_sys), .rstn(rstn), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
	// ==========
	// checking and bus tasks
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_of_test
	task automatic chk(input string what, input logic [127:0] e, input logic [127:0] g);
		tests_run++;
		if (g !== e)
		begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d, output logic [31:0] q);
		int n = 0;
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 100);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 100)
		begin
			miscompares++;
			end_of_test();
		end
	endtask : bus
	task automatic rd_chk(input logic [2:0] a, input logic [31:0] m, input logic [31:0] e, input string what);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(what, 128'(e), 128'(q & m));
	endtask : rd_chk
	// driver side: list written tail first, head published last
	task automatic publish(input int head, input int n, input logic ind);
		logic [127:0] d[4];
		logic [15:0] id;
		logic [32:0] c;
		for (int i = 0; i < n; i++)
		begin
			d[i] = {~drv_wrap, 7'h00, drv_wrap, 4'h0, ind, 1'(!ind && $urandom_range(1, 0)),
				i < n - 1, 16'($urandom), $urandom, $urandom, $urandom};
			el_q.push_back({d[i][63:0], d[i][95:64], d[i][113], ind, i == n - 1});
			id = d[i][111:96];
			if ((head + i) % 4 == 3)
				drv_wrap = ~drv_wrap;
		end
		c = {1'($urandom_range(1, 0)), $urandom};
		cpl_q.push_back(c);
		used_q.push_back({BASE + 64'(head * 16), dev_wrap, 7'h00, dev_wrap, 5'h00, c[32], 1'b0, id,
			c[32] ? c[31:0] : 32'h0});
		if (head + n >= 4)
			dev_wrap = ~dev_wrap;
		@(posedge clk_sys);
		for (int i = n - 1; i > 0; i--)
			MEM.ring[(head + i) % 4] <= d[i];
		@(posedge clk_sys);
		MEM.ring[head] <= d[0];
	endtask : publish
	task automatic drain;
		int n = 0;
		while ((el_q.size() > 0 || used_q.size() > 0) && n < 3000)
		begin
			@(posedge clk_sys);
			n++;
		end
		if (n >= 3000)
		begin
			miscompares++;
			end_of_test();
		end
	endtask : drain
	// ==========
	// datapath stand-in and result watcher
	always @(posedge clk_sys)
	begin
		el_ready <= 1'($urandom_range(1, 0));
		if (cpl_valid && cpl_ready)
			cpl_valid <= 1'b0;
		else if (cpl_ready === 1'b1 && !cpl_valid && cpl_q.size() > 0 && $urandom_range(1, 0) == 1)
		begin
			{cpl_written, cpl_len} <= cpl_q.pop_front();
			cpl_valid <= 1'b1;
		end
	end
	always @(posedge clk_sys)
	begin
		if (el_valid === 1'b1 && el_ready === 1'b1)
			chk("element", el_q.size() ? 128'(el_q.pop_front()) : 'x,
				128'({el_addr, el_len, el_write, el_indirect, el_last}));
		if (mem_wr === 1'b1 && mem_ack === 1'b1)
			chk("used", used_q.size() ? used_q.pop_front() : 'x,
				{mem_addr, mem_wdata[127:112] & 16'h8082, mem_wdata[111:64]});
	end
	// ==========
	// main sequence
	initial
	begin
		logic [31:0] q;
		int h, n1, n2;
		void'($urandom(71));
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		rd_chk(prdt_pkg::REG_RING_SIZE, 32'hFFFF_FFFF, 32'h0000_0100, "ring size");
		rd_chk(prdt_pkg::REG_CTRL, 32'hFFFF_FFFF, 32'h0, "control");
		bus(1'b1, 3'h7, 32'hFFFF_FFFF, q);
		rd_chk(3'h7, 32'hFFFF_FFFF, 32'h0, "unmapped");
		bus(1'b1, prdt_pkg::REG_BASE_LO, BASE[31:0], q);
		bus(1'b1, prdt_pkg::REG_BASE_HI, BASE[63:32], q);
		bus(1'b1, prdt_pkg::REG_RING_SIZE, 32'h4, q);
		bus(1'b1, prdt_pkg::REG_CTRL, 32'h1, q);
		rd_chk(prdt_pkg::REG_STATUS, 32'h11, 32'h11, "wrap at start");
		// a zeroed ring must stay untouched
		repeat (40) @(posedge clk_sys);
		h = 0;
		repeat (6)
		begin
			n1 = $urandom_range(2, 1);
			n2 = $urandom_range(2, 1);
			publish(h, n1, n1 == 1 && $urandom_range(1, 0) == 1);
			publish((h + n1) % 4, n2, 1'b0);
			h = (h + n1 + n2) % 4;
			drain();
			rd_chk(prdt_pkg::REG_STATUS, 32'h1, 32'(dev_wrap), "device wrap");
			rd_chk(prdt_pkg::REG_POSITION, 32'hFFFF_FFFF, {16'(h), 16'(h)}, "position");
		end
		// a cap of one halts a two-slot list on its second fetch
		bus(1'b1, prdt_pkg::REG_MAX_CHAIN, 32'h1, q);
		publish(h, 2, 1'b0);
		repeat (200) @(posedge clk_sys);
		rd_chk(prdt_pkg::REG_STATUS, 32'h6, 32'h6, "chain too long");
		bus(1'b1, prdt_pkg::REG_CTRL, 32'h2, q);
		rd_chk(prdt_pkg::REG_STATUS, 32'h6, 32'h0, "errors cleared");
		end_of_test();
	end
endmodule : testbench

// File: verilog/prdt_pkg.sv
// Function
// RULE1: both wrap counters start at one
// RULE2: driver toggles wrap after publishing last slot
// RULE3: device toggles wrap after last slot used
// RULE4: avail flag bit 7, used bit 15
// RULE5: driver sets avail=wrap, used=not wrap
// RULE6: device writes avail and used equal wrap
// RULE7: poll only next slot, circular order
// RULE8: one used descriptor per batch, skip rest
// RULE9: flag value 2 marks device-writable element
// RULE10: used writable flag only if data written
// RULE11: address is element start, length bytes
// RULE12: used length is bytes written, else reserved
// RULE13: each list uses one descriptor type only
// RULE14: exactly one used descriptor per list
// RULE15: list length capped, default queue size
// RULE16: next flag 1 continues chain to following
// RULE17: buffer id taken from last list descriptor
// RULE18: driver publishes list head last
// RULE19: driver sets flags in every list descriptor
// RULE20: driver remembers list length per id
// RULE21: used descriptor overwrites list's first slot
// RULE22: driver ignores next flag in used descriptors
// RULE23: consume only after avail marker changes
// RULE24: start in ring order, use in completion order
// RULE25: available when avail=wrap and used=not wrap
package prdt_pkg;
	// ==========================================================
	// register word indices on the slave bus
	localparam logic [2:0] REG_CTRL      = 3'h0;
	localparam logic [2:0] REG_BASE_LO   = 3'h1;
	localparam logic [2:0] REG_BASE_HI   = 3'h2;
	localparam logic [2:0] REG_RING_SIZE = 3'h3;
	localparam logic [2:0] REG_MAX_CHAIN = 3'h4;
	localparam logic [2:0] REG_STATUS    = 3'h5;
	localparam logic [2:0] REG_POSITION  = 3'h6;
	localparam int CTRL_EN_BIT   = 0;
	localparam int CTRL_CLR_BIT  = 1;
	localparam int STAT_WRAP_BIT = 0;
	localparam int STAT_BUSY_BIT = 1;
	localparam int STAT_ELEN_BIT = 2;
	localparam int STAT_EMIX_BIT = 3;
	localparam int STAT_RWRP_BIT = 4;
	localparam int POS_RD_LSB    = 16;
	// ==========================================================
	// descriptor layout, 16 bytes as one 128-bit word
	localparam int DESC_BYTES_LOG2 = 4;
	localparam int DESC_LEN_LSB    = 64;
	localparam int DESC_ID_LSB     = 96;
	localparam int DESC_FLAGS_LSB  = 112;
	localparam int FLAG_NEXT_BIT   = 0;
	localparam int FLAG_WRITE_BIT  = 1;
	localparam int FLAG_INDIR_BIT  = 2;
	localparam int FLAG_AVAIL_BIT  = 7;
	localparam int FLAG_USED_BIT   = 15;
	localparam logic WRAP_INIT     = 1'b1;
	localparam logic [15:0] RING_SIZE_RST = 16'h0100;
	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int POLL_GAP_NS   = 500;
	localparam int POLL_GAP_CYC  = (POLL_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// ==========================================================
	// sequencer states
	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_PREQ = 8'h02,
		ST_PWAIT = 8'h04,
		ST_GAP = 8'h08,
		ST_ELEM = 8'h10,
		ST_CPL = 8'h20,
		ST_USED = 8'h40,
		ST_ERR = 8'h80
	} prdt_state_e;
endpackage : prdt_pkg

// File: verilog/prdt_tracker.sv
`timescale 1ns/10ps
module prdt_tracker #(
	parameter int IDX_W = 16
)(
	// clock and reset
	input  wire logic                clk_sys,
	input  wire logic                rstn,
	// avalon-mm slave
	input  wire logic [2:0]          avs_address,
	input  wire logic                avs_read,
	input  wire logic                avs_write,
	input  wire logic [31:0]         avs_writedata,
	input  wire logic [3:0]          avs_byteenable,
	output logic      [31:0]         avs_readdata,
	output logic                     avs_waitrequest,
	// descriptor memory master
	output logic                     mem_rd,
	output logic                     mem_wr,
	output logic      [63:0]         mem_addr,
	output logic      [127:0]        mem_wdata,
	input  wire logic                mem_ack,
	input  wire logic [127:0]        mem_rdata,
	// element stream to the datapath
	output logic                     el_valid,
	input  wire logic                el_ready,
	output logic      [63:0]         el_addr,
	output logic      [31:0]         el_len,
	output logic                     el_write,
	output logic                     el_indirect,
	output logic                     el_last,
	// list completion from the datapath
	input  wire logic                cpl_valid,
	output logic                     cpl_ready,
	input  wire logic                cpl_written,
	input  wire logic [31:0]         cpl_len
);
	// ==========================================================
	// registers
	logic                     ctrl_en_r;
	logic [31:0]              base_lo_r;
	logic [31:0]              base_hi_r;
	logic [IDX_W-1:0]         ring_size_r;
	logic [IDX_W-1:0]         max_chain_r;
	logic                     err_len_r;
	logic                     err_mix_r;
	logic                     err_len_set_r;
	logic                     err_mix_set_r;
	logic [31:0]              rdata_nxt;
	logic                     wr_take;
	logic                     clr_err;
	prdt_pkg::prdt_state_e    state_r;
	logic [IDX_W-1:0]         used_idx_r;
	logic                     used_wrap_r;
	logic [IDX_W-1:0]         rd_idx_r;
	logic                     rd_wrap_r;
	logic [IDX_W-1:0]         cnt_r;
	logic                     ind_r;
	logic [15:0]              id_r;
	logic [7:0]               gap_r;
	logic [127:0]             desc;
	logic [15:0]              dflags;
	logic                     slot_avail;
	logic [IDX_W-1:0]         limit;
	logic [IDX_W:0]           used_sum;
	logic [IDX_W-1:0]         used_wrapped;
	logic [IDX_W:0]           used_diff;
	logic [31:0]              ring_size_m;
	logic [31:0]              max_chain_m;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		merge = (old & ~m) | (wd & m);
	endfunction : merge

	function automatic logic [63:0] slot_addr(input logic [63:0] base, input logic [IDX_W-1:0] idx);
		slot_addr = base + {{(64-IDX_W-prdt_pkg::DESC_BYTES_LOG2){1'b0}}, idx, {prdt_pkg::DESC_BYTES_LOG2{1'b0}}};
	endfunction : slot_addr

	// ==========================================================
	// bus slave: one wait state, request taken when waitrequest low
	assign wr_take = avs_write & ~avs_waitrequest;
	assign clr_err = wr_take & (avs_address == prdt_pkg::REG_CTRL)
		& avs_byteenable[0] & avs_writedata[prdt_pkg::CTRL_CLR_BIT];
	assign ring_size_m = merge({{(32-IDX_W){1'b0}}, ring_size_r}, avs_writedata, avs_byteenable);
	assign max_chain_m = merge({{(32-IDX_W){1'b0}}, max_chain_r}, avs_writedata, avs_byteenable);

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			avs_waitrequest <= 1'b1;
		else
			avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
	end

	always_comb
	begin
		rdata_nxt = 32'h0000_0000;
		case (avs_address)
			prdt_pkg::REG_CTRL:      rdata_nxt[prdt_pkg::CTRL_EN_BIT] = ctrl_en_r;
			prdt_pkg::REG_BASE_LO:   rdata_nxt = base_lo_r;
			prdt_pkg::REG_BASE_HI:   rdata_nxt = base_hi_r;
			prdt_pkg::REG_RING_SIZE: rdata_nxt[IDX_W-1:0] = ring_size_r;
			prdt_pkg::REG_MAX_CHAIN: rdata_nxt[IDX_W-1:0] = max_chain_r;
			prdt_pkg::REG_STATUS:
			begin
				rdata_nxt[prdt_pkg::STAT_WRAP_BIT] = used_wrap_r;
				rdata_nxt[prdt_pkg::STAT_BUSY_BIT] = (state_r != prdt_pkg::ST_IDLE);
				rdata_nxt[prdt_pkg::STAT_ELEN_BIT] = err_len_r;
				rdata_nxt[prdt_pkg::STAT_EMIX_BIT] = err_mix_r;
				rdata_nxt[prdt_pkg::STAT_RWRP_BIT] = rd_wrap_r;
			end
			prdt_pkg::REG_POSITION:
			begin
				rdata_nxt[IDX_W-1:0] = used_idx_r;
				rdata_nxt[prdt_pkg::POS_RD_LSB +: IDX_W] = rd_idx_r;
			end
			default: rdata_nxt = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			avs_readdata <= 32'h0000_0000;
		else if (avs_read & avs_waitrequest)
			avs_readdata <= rdata_nxt;
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			ctrl_en_r   <= 1'b0;
			base_lo_r   <= 32'h0000_0000;
			base_hi_r   <= 32'h0000_0000;
			ring_size_r <= prdt_pkg::RING_SIZE_RST[IDX_W-1:0];
			max_chain_r <= '0;
		end
		else if (wr_take)
		begin
			case (avs_address)
				prdt_pkg::REG_CTRL:
					if (avs_byteenable[0])
						ctrl_en_r <= avs_writedata[prdt_pkg::CTRL_EN_BIT];
				prdt_pkg::REG_BASE_LO:   base_lo_r <= merge(base_lo_r, avs_writedata, avs_byteenable);
				prdt_pkg::REG_BASE_HI:   base_hi_r <= merge(base_hi_r, avs_writedata, avs_byteenable);
				prdt_pkg::REG_RING_SIZE: ring_size_r <= ring_size_m[IDX_W-1:0];
				prdt_pkg::REG_MAX_CHAIN: max_chain_r <= max_chain_m[IDX_W-1:0];
				default: ;
			endcase
		end
	end

	// sticky errors; a set in the same cycle as a clear wins
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			err_len_r <= 1'b0;
			err_mix_r <= 1'b0;
		end
		else
		begin
			if (err_len_set_r)
				err_len_r <= 1'b1;
			else if (clr_err)
				err_len_r <= 1'b0;
			if (err_mix_set_r)
				err_mix_r <= 1'b1;
			else if (clr_err)
				err_mix_r <= 1'b0;
		end
	end

	// ==========================================================
	// descriptor decode
	assign desc   = mem_rdata;
	assign dflags = desc[prdt_pkg::DESC_FLAGS_LSB +: 16];
	// zeroed ring never matches a wrap of one, so untouched slots stay unseen
	assign slot_avail = (dflags[prdt_pkg::FLAG_AVAIL_BIT] == rd_wrap_r)
		&& (dflags[prdt_pkg::FLAG_USED_BIT] != rd_wrap_r); // RULE4 RULE23 RULE25
	// no cap or a cap beyond the ring falls back to the queue size
	assign limit = ((max_chain_r == '0) || (max_chain_r > ring_size_r)) ? ring_size_r : max_chain_r; // RULE15
	assign used_sum = {1'b0, used_idx_r} + {1'b0, cnt_r};
	assign used_diff = used_sum - {1'b0, ring_size_r};
	assign used_wrapped = (used_sum >= {1'b0, ring_size_r}) ? used_diff[IDX_W-1:0] : used_sum[IDX_W-1:0];

	// ==========================================================
	// sequencer: one list in flight, so lists complete in ring order
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			state_r       <= prdt_pkg::ST_IDLE;
			used_idx_r    <= '0;
			used_wrap_r   <= prdt_pkg::WRAP_INIT;
			rd_idx_r      <= '0;
			rd_wrap_r     <= prdt_pkg::WRAP_INIT;
			cnt_r         <= '0;
			ind_r         <= 1'b0;
			id_r          <= 16'h0000;
			gap_r         <= 8'h00;
			mem_rd        <= 1'b0;
			mem_wr        <= 1'b0;
			mem_addr      <= 64'h0000_0000_0000_0000;
			mem_wdata     <= 128'h0;
			el_valid      <= 1'b0;
			el_addr       <= 64'h0000_0000_0000_0000;
			el_len        <= 32'h0000_0000;
			el_write      <= 1'b0;
			el_indirect   <= 1'b0;
			el_last       <= 1'b0;
			cpl_ready     <= 1'b0;
			err_len_set_r <= 1'b0;
			err_mix_set_r <= 1'b0;
		end
		else
		begin
			err_len_set_r <= 1'b0;
			err_mix_set_r <= 1'b0;
			// disable waits for an outstanding memory cycle to finish
			if (!ctrl_en_r && state_r != prdt_pkg::ST_PWAIT && state_r != prdt_pkg::ST_USED)
			begin
				state_r   <= prdt_pkg::ST_IDLE;
				el_valid  <= 1'b0;
				cpl_ready <= 1'b0;
			end
			else
			begin
				case (state_r)
					prdt_pkg::ST_IDLE:
					begin
						used_idx_r  <= '0;
						used_wrap_r <= prdt_pkg::WRAP_INIT; // RULE1
						rd_idx_r    <= '0;
						rd_wrap_r   <= prdt_pkg::WRAP_INIT; // RULE1
						cnt_r       <= '0;
						state_r     <= prdt_pkg::ST_PREQ;
					end
					prdt_pkg::ST_PREQ:
					begin
						mem_rd   <= 1'b1;
						mem_addr <= slot_addr({base_hi_r, base_lo_r}, rd_idx_r); // RULE7
						state_r  <= prdt_pkg::ST_PWAIT;
					end
					prdt_pkg::ST_PWAIT:
						if (mem_ack)
						begin
							mem_rd <= 1'b0;
							if (!slot_avail)
							begin
								gap_r   <= 8'(prdt_pkg::POLL_GAP_CYC);
								state_r <= prdt_pkg::ST_GAP;
							end
							else if (cnt_r != '0 && dflags[prdt_pkg::FLAG_INDIR_BIT] != ind_r)
							begin
								err_mix_set_r <= 1'b1; // RULE13
								state_r       <= prdt_pkg::ST_ERR;
							end
							else if (cnt_r >= limit)
							begin
								err_len_set_r <= 1'b1; // RULE15
								state_r       <= prdt_pkg::ST_ERR;
							end
							else
							begin
								if (cnt_r == '0)
									ind_r <= dflags[prdt_pkg::FLAG_INDIR_BIT];
								cnt_r       <= cnt_r + 1'b1;
								el_addr     <= desc[63:0]; // RULE11
								el_len      <= desc[prdt_pkg::DESC_LEN_LSB +: 32]; // RULE11
								el_write    <= dflags[prdt_pkg::FLAG_WRITE_BIT]; // RULE9
								el_indirect <= dflags[prdt_pkg::FLAG_INDIR_BIT];
								el_last     <= ~dflags[prdt_pkg::FLAG_NEXT_BIT];
								id_r        <= desc[prdt_pkg::DESC_ID_LSB +: 16]; // RULE17
								el_valid    <= 1'b1; // RULE24
								state_r     <= prdt_pkg::ST_ELEM;
							end
						end
					prdt_pkg::ST_GAP:
						// back off so an idle ring does not saturate memory
						if (gap_r <= 8'h01)
							state_r <= prdt_pkg::ST_PREQ;
						else
							gap_r <= gap_r - 8'h01;
					prdt_pkg::ST_ELEM:
						if (el_ready)
						begin
							el_valid <= 1'b0;
							if (!el_last)
							begin
								// chain continues into the next slot
								if (rd_idx_r == ring_size_r - 1'b1)
								begin
									rd_idx_r  <= '0;
									rd_wrap_r <= ~rd_wrap_r;
								end
								else
									rd_idx_r <= rd_idx_r + 1'b1;
								state_r <= prdt_pkg::ST_PREQ; // RULE16
							end
							else
							begin
								cpl_ready <= 1'b1;
								state_r   <= prdt_pkg::ST_CPL;
							end
						end
					prdt_pkg::ST_CPL:
						if (cpl_valid)
						begin
							cpl_ready <= 1'b0;
							mem_wr    <= 1'b1;
							mem_addr  <= slot_addr({base_hi_r, base_lo_r}, used_idx_r); // RULE14 RULE21
							mem_wdata <= {
								used_wrap_r, 7'h00, used_wrap_r, 5'h00, cpl_written, 1'b0, // RULE6 RULE10
								id_r, // RULE8 RULE17
								cpl_written ? cpl_len : 32'h0000_0000, // RULE12
								64'h0000_0000_0000_0000};
							state_r   <= prdt_pkg::ST_USED;
						end
					prdt_pkg::ST_USED:
						if (mem_ack)
						begin
							mem_wr <= 1'b0;
							// skip the rest of the list; toggle only once it is marked used
							used_idx_r <= used_wrapped; // RULE8
							rd_idx_r   <= used_wrapped;
							if (used_sum >= {1'b0, ring_size_r})
							begin
								used_wrap_r <= ~used_wrap_r; // RULE3
								rd_wrap_r   <= ~used_wrap_r;
							end
							else
								rd_wrap_r <= used_wrap_r;
							cnt_r   <= '0;
							state_r <= ctrl_en_r ? prdt_pkg::ST_PREQ : prdt_pkg::ST_IDLE;
						end
					prdt_pkg::ST_ERR: ;
					default: state_r <= prdt_pkg::ST_IDLE;
				endcase
			end
		end
	end
endmodule : prdt_tracker
